/* hdl/rcd_consts.vh */
// Constants of the reset cause and debug force reset block.
`ifndef RCD_CONSTS_VH
`define RCD_CONSTS_VH
// ==========================================================================
// Register addresses on the local register port.
`define RCD_ADDR_W          2
`define RCD_ADDR_STATUS     2'h0
`define RCD_ADDR_FORCE      2'h1
// ==========================================================================
// Reset cause status field positions.
`define RCD_BIT_POR         7
`define RCD_BIT_PIN         6
`define RCD_BIT_WDOG        5
`define RCD_BIT_ILLEGAL_OPCODE_FLAG        4
`define RCD_BIT_ILLEGAL_ADDRESS_FLAG        3
`define RCD_BIT_LVD         1
`define RCD_BIT_FORCE       0
// ==========================================================================
// Reset values.
`define RCD_STATUS_POR_VAL  8'h82
`define RCD_FORCE_RD_VAL    8'h00
`define RCD_ZERO_BYTE       8'h00
// ==========================================================================
// Timing: internal reset hold time in ns, turned into cycles at 100 MHz.
`define RCD_CLK_PERIOD_NS   10
`define RCD_HOLD_NS         80
`define RCD_HOLD_CYC        ((`RCD_HOLD_NS + `RCD_CLK_PERIOD_NS - 1) / `RCD_CLK_PERIOD_NS)
`endif

/* hdl/rcd_rst_hold.v */
// Reset hold counter that stretches a reset request into a pulse lasting the hold time after the request ends.
`timescale 1ns/10ps
`default_nettype none
module rcd_rst_hold #(
  parameter integer CNT_W    = 8,
  parameter integer HOLD_CYC = 8
) (
  // Clock and reset
  input  wire clk_sys_i,
  input  wire rst_b_i,
  // Request and hold
  input  wire start_i,
  output wire busy_o
);
  localparam [CNT_W-1:0] HOLD_VAL = HOLD_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] ONE      = {{(CNT_W-1){1'b0}}, 1'b1};
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  // ==========================================================================
  // Counter
  // A request that stays active keeps reloading, so reset lasts at least the
  // hold time after the last active source.
  always @* begin
    cnt_d = cnt_q;
    if (start_i) begin
      cnt_d = HOLD_VAL;
    end else if (cnt_q != {CNT_W{1'b0}}) begin
      cnt_d = cnt_q - ONE;
    end
  end
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cnt_q <= HOLD_VAL;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign busy_o = (cnt_q != {CNT_W{1'b0}});
endmodule
`default_nettype wire

/* hdl/rcd_reset_cause.v */
// Reset cause recorder with debug-host force reset control.
`timescale 1ns/10ps
`default_nettype none
`include "rcd_consts.vh"
module rcd_reset_cause #(
  parameter integer HOLD_CYC = `RCD_HOLD_CYC
) (
  // Clock and power-on reset
  input  wire                   clk_sys_i,
  input  wire                   rst_b_i,
  // Reset sources
  input  wire                   ext_rst_b_i,
  input  wire                   wdog_timeout_i,
  input  wire                   illegal_opcode_i,
  input  wire                   stop_exec_i,
  input  wire                   background_instruction_exec_i,
  input  wire                   illegal_address_i,
  input  wire                   lvd_trip_i,
  // Option bits
  input  wire                   watchdog_enable_i,
  input  wire                   stop_enable_i,
  input  wire                   background_mode_enable_i,
  input  wire                   low_voltage_reset_enable_i,
  // User program register port
  input  wire                   cpu_wr_i,
  input  wire                   cpu_rd_i,
  input  wire [`RCD_ADDR_W-1:0] cpu_addr_i,
  input  wire [7:0]             cpu_wdata_i,
  output reg  [7:0]             cpu_rdata_o,
  // Background debug write port
  input  wire                   bdm_wr_i,
  input  wire [`RCD_ADDR_W-1:0] bdm_addr_i,
  input  wire [7:0]             bdm_wdata_i,
  // Mode select pin sampled at reset release
  input  wire                   debug_mode_select_pin_i,
  // System outputs
  output wire                   mcu_rst_o,
  output reg                    wdog_restart_o,
  output reg                    boot_bdm_o,
  output wire [7:0]             reset_cause_status_o
);
  reg  [7:0] status_q;
  reg  [7:0] status_d;
  reg        force_q;
  reg        busy_dly_q;
  wire       busy;
  wire       src_pin;
  wire       src_wdog;
  wire       src_illegal_opcode_flag;
  wire       src_illegal_address_flag;
  wire       src_lvd;
  wire       src_force;
  wire       any_src;
  wire       entry;
  wire       cpu_wr_status;
  wire       bdm_wr_status;
  // ==========================================================================
  // Address decode, shared by both ports so they can never disagree.
  function addr_is;
    input [`RCD_ADDR_W-1:0] addr;
    input [`RCD_ADDR_W-1:0] want;
    begin
      addr_is = (addr == want);
    end
  endfunction
  // ==========================================================================
  // Reset sources
  assign src_pin   = ~ext_rst_b_i;
  assign src_wdog  = wdog_timeout_i & watchdog_enable_i;
  assign src_illegal_opcode_flag  = illegal_opcode_i | (stop_exec_i & ~stop_enable_i)
                   | (background_instruction_exec_i & ~background_mode_enable_i);
  assign src_illegal_address_flag  = illegal_address_i;
  assign src_lvd   = lvd_trip_i & low_voltage_reset_enable_i;
  // Only the background port can set the force bit; the user port never
  // reaches it, so a runaway program cannot fake a debug reset.
  assign src_force = bdm_wr_i & addr_is(bdm_addr_i, `RCD_ADDR_FORCE)
                   & bdm_wdata_i[`RCD_BIT_FORCE];
  assign any_src   = src_pin | src_wdog | src_illegal_opcode_flag | src_illegal_address_flag | src_lvd | src_force | force_q;
  assign entry     = any_src & ~busy;
  // ==========================================================================
  // Reset stretcher
  rcd_rst_hold #(
    .CNT_W    (8),
    .HOLD_CYC (HOLD_CYC)
  ) u_hold (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .start_i   (any_src),
    .busy_o    (busy)
  );
  assign mcu_rst_o = busy;
  // ==========================================================================
  // Cause capture
  // Flags are taken once at reset entry; sources that appear while reset is
  // already held only stretch it and do not rewrite the record.
  always @* begin
    status_d = status_q;
    if (entry) begin
      if (src_lvd) begin
        status_d = `RCD_ZERO_BYTE;
        status_d[`RCD_BIT_POR] = status_q[`RCD_BIT_POR];
        status_d[`RCD_BIT_LVD] = 1'b1;
      end else if (src_force | force_q) begin
        status_d = `RCD_ZERO_BYTE;
      end else begin
        status_d = `RCD_ZERO_BYTE;
        status_d[`RCD_BIT_PIN]  = src_pin;
        status_d[`RCD_BIT_WDOG] = src_wdog;
        status_d[`RCD_BIT_ILLEGAL_OPCODE_FLAG] = src_illegal_opcode_flag;
        status_d[`RCD_BIT_ILLEGAL_ADDRESS_FLAG] = src_illegal_address_flag;
      end
    end
  end
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      status_q <= `RCD_STATUS_POR_VAL;
    end else begin
      status_q <= status_d;
    end
  end
  assign reset_cause_status_o = status_q;
  // ==========================================================================
  // Force request latch, held until the reset it causes has begun.
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      force_q <= 1'b0;
    end else if (src_force) begin
      force_q <= 1'b1;
    end else if (busy) begin
      force_q <= 1'b0;
    end
  end
  // ==========================================================================
  // Watchdog restart on a write to the cause register address
  assign cpu_wr_status = cpu_wr_i & addr_is(cpu_addr_i, `RCD_ADDR_STATUS) & ~busy;
  assign bdm_wr_status = bdm_wr_i & addr_is(bdm_addr_i, `RCD_ADDR_STATUS) & ~busy;
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      wdog_restart_o <= 1'b0;
    end else begin
      wdog_restart_o <= cpu_wr_status | bdm_wr_status;
    end
  end
  // ==========================================================================
  // Read port
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cpu_rdata_o <= `RCD_ZERO_BYTE;
    end else if (cpu_rd_i) begin
      case (cpu_addr_i)
        `RCD_ADDR_STATUS: begin
          cpu_rdata_o <= status_q & 8'hFA;
        end
        `RCD_ADDR_FORCE: begin
          cpu_rdata_o <= `RCD_FORCE_RD_VAL;
        end
        default: begin
          cpu_rdata_o <= `RCD_ZERO_BYTE;
        end
      endcase
    end
  end
  // ==========================================================================
  // Boot mode capture
  // The pin is sampled on the first clock edge after the internal reset falls,
  // which is the moment the host must already be driving the wanted level.
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      busy_dly_q <= 1'b1;
      boot_bdm_o <= 1'b0;
    end else begin
      busy_dly_q <= busy;
      if (busy_dly_q & ~busy) begin
        boot_bdm_o <= ~debug_mode_select_pin_i;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/rcd_asserts.sv */
// Port checker for the reset cause recorder.
`timescale 1ns/10ps
`default_nettype none
module rcd_asserts (
  input wire logic       clk_sys_i, rst_b_i, ext_rst_b_i, wdog_timeout_i, watchdog_enable_i,
  input wire logic       lvd_trip_i, low_voltage_reset_enable_i, cpu_wr_i, cpu_rd_i,
  input wire logic [1:0] cpu_addr_i, bdm_addr_i,
  input wire logic [7:0] bdm_wdata_i, cpu_rdata_o, reset_cause_status_o,
  input wire logic       bdm_wr_i, debug_mode_select_pin_i, mcu_rst_o, wdog_restart_o, boot_bdm_o
);
  // ==========================================================================
  // Checks. Run excludes the two sources that outrank the ordinary ones.
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  wire logic run = !mcu_rst_o && !lvd_trip_i && !bdm_wr_i;
  status_read_a: assert property (cpu_rd_i && cpu_addr_i == 2'h0 |=>
    cpu_rdata_o == ($past(reset_cause_status_o) & 8'hFA)) else $error("status read wrong");
  force_read_a: assert property (cpu_rd_i && cpu_addr_i != 2'h0 |=>
    cpu_rdata_o == 8'h00) else $error("read not zero");
  spare_bits_a: assert property (reset_cause_status_o[2] == 1'b0 &&
    reset_cause_status_o[0] == 1'b0) else $error("spare bit set");
  wdog_clear_a: assert property (cpu_wr_i && cpu_addr_i == 2'h0 && !mcu_rst_o |=>
    wdog_restart_o) else $error("no watchdog restart");
  force_reset_a: assert property (!mcu_rst_o && !lvd_trip_i && bdm_wr_i &&
    bdm_addr_i == 2'h1 && bdm_wdata_i[0] |=> mcu_rst_o && reset_cause_status_o == 8'h00)
    else $error("force reset wrong");
  pin_reset_a: assert property (run && !ext_rst_b_i |=> mcu_rst_o &&
    reset_cause_status_o[7:6] == 2'b01 && !reset_cause_status_o[1]) else $error("pin reset");
  wdog_reset_a: assert property (run && wdog_timeout_i && watchdog_enable_i |=>
    mcu_rst_o && reset_cause_status_o[5]) else $error("watchdog reset");
  lvd_reset_a: assert property (!mcu_rst_o && lvd_trip_i && low_voltage_reset_enable_i |=>
    mcu_rst_o && reset_cause_status_o[6:0] == 7'h02 &&
    reset_cause_status_o[7] == $past(reset_cause_status_o[7])) else $error("lvd reset");
  boot_mode_a: assert property ($fell(mcu_rst_o) |=>
    boot_bdm_o == !$past(debug_mode_select_pin_i)) else $error("boot mode wrong");
  cover property (run && !ext_rst_b_i);
  cover property (bdm_wr_i && bdm_addr_i == 2'h1);
  cover property (wdog_restart_o);
endmodule
bind rcd_reset_cause rcd_asserts rcd_asserts_i (.*);
`default_nettype wire

/* tb/rcd_host_model.sv */
// Debug host model driving the background write port and the mode pin.
`timescale 1ns/10ps
`default_nettype none
module rcd_host_model (
  // Clock and command
  input  wire logic       clk_sys_i,
  input  wire logic       go_i,
  input  wire logic       mode_i,
  // Background port and mode pin
  output var  logic       bdm_wr_o,
  output var  logic [1:0] bdm_addr_o,
  output var  logic [7:0] bdm_wdata_o,
  output var  logic       ms_pin_o
);
  // ==========================================================================
  // Idle lines carry the inverse of the write, so a stale copy cannot pass.
  initial begin
    bdm_wr_o = 1'b0;
    ms_pin_o = 1'b1;
  end
  always @(posedge clk_sys_i) begin
    bdm_wr_o    <= go_i;
    bdm_addr_o  <= go_i ? 2'h1 : 2'h2;
    bdm_wdata_o <= go_i ? 8'h01 : 8'hFE;
    if (bdm_wr_o) begin
      ms_pin_o <= mode_i;
    end
  end
endmodule
`default_nettype wire

/* tb/rcd_reset_cause_bench.sv */
// Self-checking bench for the reset cause recorder.
`timescale 1ns/10ps
`default_nettype none
module rcd_reset_cause_bench;
  // ==========================================================================
  // Stimulus and checks.
  logic       clk_sys_i = 0, rst_b_i = 0, rd = 0, wr = 0, go = 0, mode = 1;
  logic [1:0] addr = 0, ba;
  logic [7:0] wd = 0, src = 0, st, bd, rdata;
  logic [3:0] en = 4'hF;
  logic       bw, ms, rst, rs, boot;
  int         error_cnt = 0, checks = 0, cyc = 0, n;
  always #5 clk_sys_i = ~clk_sys_i;
  rcd_reset_cause rcd_reset_cause_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .ext_rst_b_i(!src[6]), .wdog_timeout_i(src[5]), .illegal_opcode_i(src[4]),
    .stop_exec_i(src[2]), .background_instruction_exec_i(src[0]), .illegal_address_i(src[3]),
    .lvd_trip_i(src[1]), .watchdog_enable_i(en[3]), .stop_enable_i(en[2]),
    .background_mode_enable_i(en[1]), .low_voltage_reset_enable_i(en[0]),
    .cpu_wr_i(wr), .cpu_rd_i(rd), .cpu_addr_i(addr), .cpu_wdata_i(wd), .cpu_rdata_o(rdata),
    .bdm_wr_i(bw), .bdm_addr_i(ba), .bdm_wdata_i(bd), .debug_mode_select_pin_i(ms),
    .mcu_rst_o(rst), .wdog_restart_o(rs), .boot_bdm_o(boot), .reset_cause_status_o(st));
  rcd_host_model rcd_host_model_i (.clk_sys_i(clk_sys_i), .go_i(go), .mode_i(mode),
    .bdm_wr_o(bw), .bdm_addr_o(ba), .bdm_wdata_o(bd), .ms_pin_o(ms));
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  task automatic idle;
    n = 0;
    while (rst === 1'b1 && n < 100) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
  endtask
  task automatic rdc(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    rd <= 1;
    addr <= a;
    @(posedge clk_sys_i);
    rd <= 0;
    #1 cmp("read", e, rdata);
  endtask
  task automatic wrc(input logic [1:0] a, input logic [7:0] d, input logic e);
    @(posedge clk_sys_i);
    wr <= 1;
    addr <= a;
    wd <= d;
    @(posedge clk_sys_i);
    wr <= 0;
    #1 cmp("restart", {7'h00, e}, {7'h00, rs});
    cmp("reset", 8'h00, {7'h00, rst});
  endtask
  task automatic hit(input logic [7:0] s, input logic [3:0] e, input logic r, input logic [7:0] x);
    @(posedge clk_sys_i);
    src <= s;
    en <= e;
    @(posedge clk_sys_i);
    src <= 0;
    #1 cmp("reset", {7'h00, r}, {7'h00, rst});
    cmp("status", x, st);
    idle;
  endtask
  task automatic frc(input logic m);
    @(posedge clk_sys_i);
    go <= 1;
    mode <= m;
    @(posedge clk_sys_i);
    go <= 0;
    @(posedge clk_sys_i);
    #1 cmp("reset", 8'h01, {7'h00, rst});
    cmp("status", 8'h00, st);
    idle;
    @(posedge clk_sys_i);
    #1 cmp("boot", {7'h00, !m}, {7'h00, boot});
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_b_i <= 1;
    #1 idle;
    rdc(2'h0, 8'h82);
    rdc(2'h1, 8'h00);
    rdc(2'h3, 8'h00);
    wrc(2'h0, 8'hFF, 1);
    rdc(2'h0, 8'h82);
    wrc(2'h1, 8'h01, 0);
    rdc(2'h1, 8'h00);
    hit(8'h40, 4'hF, 1, 8'h40);
    cmp("hold", 8'h08, n[7:0]);
    hit(8'h20, 4'hF, 1, 8'h20);
    hit(8'h20, 4'h7, 0, 8'h20);
    hit(8'h10, 4'hF, 1, 8'h10);
    hit(8'h04, 4'hB, 1, 8'h10);
    hit(8'h04, 4'hF, 0, 8'h10);
    hit(8'h01, 4'hD, 1, 8'h10);
    hit(8'h01, 4'hF, 0, 8'h10);
    hit(8'h08, 4'hF, 1, 8'h08);
    hit(8'h68, 4'hF, 1, 8'h68);
    hit(8'h02, 4'hE, 0, 8'h68);
    hit(8'h02, 4'hF, 1, 8'h02);
    frc(0);
    rdc(2'h0, 8'h00);
    frc(1);
    @(posedge clk_sys_i);
    rst_b_i <= 0;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1;
    #1 idle;
    hit(8'h02, 4'hF, 1, 8'h82);
    report_and_stop;
  end
endmodule
`default_nettype wire
